//--- common/pchr_pkg.sv
// package: constants, offsets and carrier types for the configuration header register bank
// Behaviour
// [R1] status register reads 0x0080 after reset; fields are all fixed constants
// [R2] parity, abort and master parity error status bits always read 0, writes ignored
// [R3] signaled system error bit 14 always reads 0; writes to it do nothing
// [R4] select timing field bits 10:9 always reads 00, fast decode, writes ignored
// [R5] status bit 7 always reads 1, fast back-to-back capable, writes ignored
// [R6] capability list flag bit 4 always reads 0
// [R7] revision code at 0x08 is read-only fixed value; writes do nothing
// [R8] sub class code at 0x0A is read-only and returns 0x80
// [R9] base class code at 0x0B is read-only and returns 0x08
// [R10] header type byte at 0x0E reads 0x80, multifunction device
// [R11] header type has no storage; value combinational, accesses change no state
// [R12] subsystem vendor code at 0x2C-0x2D resets to zero, takes first write, then locks
// [R13] boot firmware writes subsystem vendor code once at start-up
// [R14] reserved status bits 6:5 and 3:0 read zero and ignore writes
package pchr_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  typedef logic [ADDR_W-1:0] pchr_addr_t;
  typedef logic [DATA_W-1:0] pchr_byte_t;

  // byte offsets in configuration space
  localparam pchr_addr_t OFS_STATUS_LO   = 8'h06;
  localparam pchr_addr_t OFS_STATUS_HI   = 8'h07;
  localparam pchr_addr_t OFS_REVISION    = 8'h08;
  localparam pchr_addr_t OFS_SUB_CLASS   = 8'h0a;
  localparam pchr_addr_t OFS_BASE_CLASS  = 8'h0b;
  localparam pchr_addr_t OFS_HEADER_TYPE = 8'h0e;
  localparam pchr_addr_t OFS_SUBSYSTEM_VENDOR_CODE_LO     = 8'h2c;
  localparam pchr_addr_t OFS_SUBSYSTEM_VENDOR_CODE_HI     = 8'h2d;

  // fixed contents
  localparam logic [15:0] STATUS_RESET     = 16'h0080;
  localparam pchr_byte_t  SUB_CLASS_VALUE  = 8'h80;
  localparam pchr_byte_t  BASE_CLASS_VALUE = 8'h08;
  localparam pchr_byte_t  HEADER_VALUE     = 8'h80;
  localparam logic [15:0] SUBSYSTEM_VENDOR_CODE_RESET       = 16'h0000;
  localparam pchr_byte_t  RDATA_RESET      = 8'h00;
  localparam pchr_byte_t  UNMAPPED_VALUE   = 8'h00;

  // status register layout
  typedef struct packed {
    logic       parity_error_seen;
    logic       system_error_signaled;
    logic       master_abort_received;
    logic       target_abort_received;
    logic       target_abort_signaled;
    logic [1:0] select_timing;
    logic       master_parity_error;
    logic       fast_back_to_back;
    logic [1:0] reserved_hi;
    logic       capability_list_flag;
    logic [3:0] reserved_lo;
  } pchr_status_s;

  // configuration access request, one byte per access
  typedef struct packed {
    logic       rd;
    logic       wr;
    pchr_addr_t addr;
    pchr_byte_t wdata;
  } pchr_cfg_req_s;

endpackage

//--- hdl/pchr_regs.sv
// configuration header register bank: status, class codes, header type, write-once subsystem vendor code
`timescale 1ns/1ps
`default_nettype none

module pchr_regs
  import pchr_pkg::*;
#(
  // arbitrary value, not a real part revision
  parameter pchr_byte_t REVISION_VALUE = 8'h01
)
(
  input  wire logic          i_clk,
  input  wire logic          i_reset,
  input  wire pchr_cfg_req_s i_cfg,
  output logic [7:0]         o_cfg_rdata,
  output logic               o_cfg_rvalid,
  output logic [15:0]        o_subsystem_vendor_code
);

  logic [15:0] subsystem_vendor_code_reg;
  logic [1:0]  subsystem_vendor_code_lock_reg;
  pchr_byte_t  rdata_reg;
  pchr_byte_t  rdata_next;
  logic        rvalid_reg;
  logic [1:0]  subsystem_vendor_code_wr;

  function automatic logic hit(input pchr_cfg_req_s req, input pchr_addr_t ofs);
    hit = (req.addr == ofs);
  endfunction

  // status word built from constant fields only, so no write can reach it
  function automatic pchr_status_s status_value();
    pchr_status_s s;
    s = pchr_status_s'(STATUS_RESET);              // R1
    s.parity_error_seen     = 1'b0;                // R2
    s.target_abort_signaled = 1'b0;                // R2
    s.target_abort_received = 1'b0;                // R2
    s.master_abort_received = 1'b0;                // R2
    s.master_parity_error   = 1'b0;                // R2
    s.system_error_signaled = 1'b0;                // R3
    s.select_timing         = 2'b00;               // R4
    s.fast_back_to_back     = 1'b1;                // R5
    s.capability_list_flag  = 1'b0;                // R6
    s.reserved_hi           = 2'b00;               // R14
    s.reserved_lo           = 4'h0;                // R14
    status_value = s;
  endfunction

  // byte read mux; header type comes from a constant, no storage behind it
  function automatic pchr_byte_t read_mux(input pchr_addr_t a, input logic [15:0] subsystem_vendor_code);
    pchr_status_s st;
    st = status_value();
    case (a)
      OFS_STATUS_LO:   read_mux = st[7:0];         // R1
      OFS_STATUS_HI:   read_mux = st[15:8];        // R1
      OFS_REVISION:    read_mux = REVISION_VALUE;  // R7
      OFS_SUB_CLASS:   read_mux = SUB_CLASS_VALUE; // R8
      OFS_BASE_CLASS:  read_mux = BASE_CLASS_VALUE; // R9
      OFS_HEADER_TYPE: read_mux = HEADER_VALUE;    // R10 R11
      OFS_SUBSYSTEM_VENDOR_CODE_LO:     read_mux = subsystem_vendor_code[7:0];
      OFS_SUBSYSTEM_VENDOR_CODE_HI:     read_mux = subsystem_vendor_code[15:8];
      default:         read_mux = UNMAPPED_VALUE;
    endcase
  endfunction

  // write decode: only the subsystem vendor bytes have storage
  always_comb
  begin
    subsystem_vendor_code_wr[0] = i_cfg.wr && hit(i_cfg, OFS_SUBSYSTEM_VENDOR_CODE_LO) && !subsystem_vendor_code_lock_reg[0]; // R12
    subsystem_vendor_code_wr[1] = i_cfg.wr && hit(i_cfg, OFS_SUBSYSTEM_VENDOR_CODE_HI) && !subsystem_vendor_code_lock_reg[1]; // R12
  end

  // subsystem vendor code storage, per byte
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      subsystem_vendor_code_reg <= SUBSYSTEM_VENDOR_CODE_RESET;                      // R12
    end
    else
    begin
      if (subsystem_vendor_code_wr[0])
      begin
        subsystem_vendor_code_reg[7:0] <= i_cfg.wdata;              // R12
      end
      if (subsystem_vendor_code_wr[1])
      begin
        subsystem_vendor_code_reg[15:8] <= i_cfg.wdata;             // R12
      end
    end
  end

  // write-once locks; the first write to a byte locks it until reset
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      subsystem_vendor_code_lock_reg <= 2'b00;
    end
    else
    begin
      subsystem_vendor_code_lock_reg <= subsystem_vendor_code_lock_reg | subsystem_vendor_code_wr;    // R12
    end
  end

  // read data path, answered one cycle after the request
  always_comb
  begin
    rdata_next = i_cfg.rd ? read_mux(i_cfg.addr, subsystem_vendor_code_reg) : rdata_reg;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      rdata_reg  <= RDATA_RESET;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= i_cfg.rd;
    end
  end

  assign o_cfg_rdata             = rdata_reg;
  assign o_cfg_rvalid            = rvalid_reg;
  assign o_subsystem_vendor_code = subsystem_vendor_code_reg;

  // expected status bytes for the checks
  localparam pchr_byte_t EXP_STATUS_LO = 8'h80;
  localparam pchr_byte_t EXP_STATUS_HI = 8'h00;

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  a_status_low_read: // R1
    assert property (i_cfg.rd && i_cfg.addr == OFS_STATUS_LO |=> o_cfg_rvalid && o_cfg_rdata == 8'h80)
    else $error("status low byte not 0x80");

  a_status_error_bits: // R2
    assert property (i_cfg.rd && i_cfg.addr == OFS_STATUS_HI
                     |=> o_cfg_rdata[7] == 1'b0 && o_cfg_rdata[5:3] == 3'b000 && o_cfg_rdata[0] == 1'b0)
    else $error("status error bit reads nonzero");

  a_system_error_zero: // R3
    assert property (i_cfg.wr && i_cfg.addr == OFS_STATUS_HI ##1 i_cfg.rd && i_cfg.addr == OFS_STATUS_HI
                     |=> o_cfg_rdata[6] == 1'b0)
    else $error("system error bit reads set after write");

  a_select_timing_fast: // R4
    assert property (i_cfg.rd && i_cfg.addr == OFS_STATUS_HI |=> o_cfg_rdata[2:1] == 2'b00)
    else $error("select timing not fast decode");

  a_fast_b2b_set: // R5
    assert property (i_cfg.wr && i_cfg.addr == OFS_STATUS_LO ##1 i_cfg.rd && i_cfg.addr == OFS_STATUS_LO
                     |=> o_cfg_rdata[7] == 1'b1)
    else $error("fast back-to-back bit not set");

  a_cap_list_clear: // R6
    assert property (i_cfg.rd && i_cfg.addr == OFS_STATUS_LO |=> o_cfg_rdata[4] == 1'b0)
    else $error("capability list flag set");

  a_revision_fixed: // R7
    assert property (i_cfg.rd && i_cfg.addr == OFS_REVISION |=> o_cfg_rdata == $past(REVISION_VALUE))
    else $error("revision code wrong");

  a_sub_class_value: // R8
    assert property (i_cfg.rd && i_cfg.addr == OFS_SUB_CLASS |=> o_cfg_rdata == 8'h80)
    else $error("sub class code wrong");

  a_base_class_value: // R9
    assert property (i_cfg.rd && i_cfg.addr == OFS_BASE_CLASS |=> o_cfg_rdata == 8'h08)
    else $error("base class code wrong");

  a_header_type_value: // R10
    assert property (i_cfg.rd && i_cfg.addr == OFS_HEADER_TYPE |=> o_cfg_rdata == 8'h80)
    else $error("header type wrong");

  a_header_no_state: // R11
    assert property (i_cfg.wr && i_cfg.addr == OFS_HEADER_TYPE && !i_cfg.rd
                     |=> $stable(subsystem_vendor_code_reg) && $stable(subsystem_vendor_code_lock_reg) && $stable(o_cfg_rdata))
    else $error("header type access changed state");

  a_subsystem_vendor_code_first_write: // R12
    assert property (i_cfg.wr && i_cfg.addr == OFS_SUBSYSTEM_VENDOR_CODE_LO && !subsystem_vendor_code_lock_reg[0]
                     |=> subsystem_vendor_code_reg[7:0] == $past(i_cfg.wdata) && subsystem_vendor_code_lock_reg[0])
    else $error("subsystem vendor first write lost");

  a_subsystem_vendor_code_locked: // R12
    assert property (subsystem_vendor_code_lock_reg[1] |=> $stable(subsystem_vendor_code_reg[15:8]) && subsystem_vendor_code_lock_reg[1])
    else $error("locked subsystem vendor byte changed");

  a_subsystem_vendor_code_after_reset: // R12
    assert property (@(posedge i_clk) $past(i_reset) |-> subsystem_vendor_code_reg == 16'h0000 && subsystem_vendor_code_lock_reg == 2'b00)
    else $error("subsystem vendor not cleared by reset");

  a_reserved_zero: // R14
    assert property (i_cfg.rd && i_cfg.addr == OFS_STATUS_LO |=> o_cfg_rdata[6:5] == 2'b00 && o_cfg_rdata[3:0] == 4'h0)
    else $error("reserved status bits nonzero");

  a_rvalid_follows_read: // R7
    assert property (i_cfg.rd |=> o_cfg_rvalid)
    else $error("read not answered");

  a_rvalid_idle: // R11
    assert property (!i_cfg.rd |=> !o_cfg_rvalid)
    else $error("valid without read");

  a_rdata_holds: // R11
    assert property (!i_cfg.rd |=> $stable(o_cfg_rdata))
    else $error("read data moved without read");

  a_status_hi_zero: // R2
    assert property (i_cfg.rd && i_cfg.addr == OFS_STATUS_HI |=> o_cfg_rdata == EXP_STATUS_HI)
    else $error("status high byte not zero");

  a_status_lo_after_write: // R1
    assert property (i_cfg.wr && i_cfg.addr == OFS_STATUS_LO ##1 i_cfg.rd && i_cfg.addr == OFS_STATUS_LO
                     |=> o_cfg_rdata == EXP_STATUS_LO)
    else $error("status low byte changed by write");

  a_status_hi_after_write: // R3
    assert property (i_cfg.wr && i_cfg.addr == OFS_STATUS_HI ##1 i_cfg.rd && i_cfg.addr == OFS_STATUS_HI
                     |=> o_cfg_rdata == EXP_STATUS_HI)
    else $error("status high byte changed by write");

  a_reserved_after_write: // R14
    assert property (i_cfg.wr && i_cfg.addr == OFS_STATUS_LO ##1 i_cfg.rd && i_cfg.addr == OFS_STATUS_LO
                     |=> o_cfg_rdata[6:5] == 2'b00 && o_cfg_rdata[3:0] == 4'h0)
    else $error("reserved status bits set by write");

  a_cap_after_write: // R6
    assert property (i_cfg.wr && i_cfg.addr == OFS_STATUS_LO ##1 i_cfg.rd && i_cfg.addr == OFS_STATUS_LO
                     |=> o_cfg_rdata[4] == 1'b0)
    else $error("capability list flag set by write");

  a_revision_after_write: // R7
    assert property (i_cfg.wr && i_cfg.addr == OFS_REVISION ##1 i_cfg.rd && i_cfg.addr == OFS_REVISION
                     |=> o_cfg_rdata == REVISION_VALUE)
    else $error("revision code changed by write");

  a_sub_class_after_write: // R8
    assert property (i_cfg.wr && i_cfg.addr == OFS_SUB_CLASS ##1 i_cfg.rd && i_cfg.addr == OFS_SUB_CLASS
                     |=> o_cfg_rdata == 8'h80)
    else $error("sub class code changed by write");

  a_base_class_after_write: // R9
    assert property (i_cfg.wr && i_cfg.addr == OFS_BASE_CLASS ##1 i_cfg.rd && i_cfg.addr == OFS_BASE_CLASS
                     |=> o_cfg_rdata == 8'h08)
    else $error("base class code changed by write");

  a_header_after_write: // R10
    assert property (i_cfg.wr && i_cfg.addr == OFS_HEADER_TYPE ##1 i_cfg.rd && i_cfg.addr == OFS_HEADER_TYPE
                     |=> o_cfg_rdata == 8'h80)
    else $error("header type changed by write");

  a_subsystem_vendor_code_hi_first_write: // R12
    assert property (i_cfg.wr && i_cfg.addr == OFS_SUBSYSTEM_VENDOR_CODE_HI && !subsystem_vendor_code_lock_reg[1]
                     |=> subsystem_vendor_code_reg[15:8] == $past(i_cfg.wdata) && subsystem_vendor_code_lock_reg[1])
    else $error("subsystem vendor high first write lost");

  a_subsystem_vendor_code_lo_locked: // R12
    assert property (subsystem_vendor_code_lock_reg[0] |=> $stable(subsystem_vendor_code_reg[7:0]) && subsystem_vendor_code_lock_reg[0])
    else $error("locked subsystem vendor low byte changed");

  a_subsystem_vendor_code_lo_ignored: // R12
    assert property (i_cfg.wr && i_cfg.addr == OFS_SUBSYSTEM_VENDOR_CODE_LO && subsystem_vendor_code_lock_reg[0]
                     |=> subsystem_vendor_code_reg[7:0] == $past(subsystem_vendor_code_reg[7:0]))
    else $error("locked low byte took a write");

  a_subsystem_vendor_code_hi_ignored: // R12
    assert property (i_cfg.wr && i_cfg.addr == OFS_SUBSYSTEM_VENDOR_CODE_HI && subsystem_vendor_code_lock_reg[1]
                     |=> subsystem_vendor_code_reg[15:8] == $past(subsystem_vendor_code_reg[15:8]))
    else $error("locked high byte took a write");

  a_subsystem_vendor_code_read_lo: // R12
    assert property (i_cfg.rd && i_cfg.addr == OFS_SUBSYSTEM_VENDOR_CODE_LO |=> o_cfg_rdata == $past(subsystem_vendor_code_reg[7:0]))
    else $error("subsystem vendor low read wrong");

  a_subsystem_vendor_code_read_hi: // R12
    assert property (i_cfg.rd && i_cfg.addr == OFS_SUBSYSTEM_VENDOR_CODE_HI |=> o_cfg_rdata == $past(subsystem_vendor_code_reg[15:8]))
    else $error("subsystem vendor high read wrong");

  a_subsystem_vendor_code_only_on_write: // R12
    assert property (!i_cfg.wr |=> $stable(subsystem_vendor_code_reg) && $stable(subsystem_vendor_code_lock_reg))
    else $error("subsystem vendor changed without write");

  a_lock_lo_needs_write: // R12
    assert property (!subsystem_vendor_code_lock_reg[0] && !(i_cfg.wr && i_cfg.addr == OFS_SUBSYSTEM_VENDOR_CODE_LO) |=> !subsystem_vendor_code_lock_reg[0])
    else $error("low byte locked without write");

  a_lock_hi_needs_write: // R12
    assert property (!subsystem_vendor_code_lock_reg[1] && !(i_cfg.wr && i_cfg.addr == OFS_SUBSYSTEM_VENDOR_CODE_HI) |=> !subsystem_vendor_code_lock_reg[1])
    else $error("high byte locked without write");

  a_read_path_reset: // R1
    assert property ($past(i_reset) |-> o_cfg_rdata == RDATA_RESET && !o_cfg_rvalid)
    else $error("read path not cleared by reset");

  c_subsystem_vendor_code_hi_locked_write:
    cover property (i_cfg.wr && i_cfg.addr == OFS_SUBSYSTEM_VENDOR_CODE_HI && subsystem_vendor_code_lock_reg[1]);

  c_status_read:
    cover property (i_cfg.rd && i_cfg.addr == OFS_STATUS_LO ##1 o_cfg_rvalid);

  c_subsystem_vendor_code_program:
    cover property (subsystem_vendor_code_wr[0] ##[1:4] subsystem_vendor_code_wr[1]);

  c_subsystem_vendor_code_locked_write:
    cover property (i_cfg.wr && i_cfg.addr == OFS_SUBSYSTEM_VENDOR_CODE_LO && subsystem_vendor_code_lock_reg[0]);

  c_header_read:
    cover property (i_cfg.rd && i_cfg.addr == OFS_HEADER_TYPE);

endmodule

`default_nettype wire

//--- bench/pchr_regs_tb_top.sv
// self-checking testbench for the configuration header register bank
`timescale 1ns/1ps
`default_nettype none

module pchr_regs_tb_top
  import pchr_pkg::*;
;
  // arbitrary revision value, not a real part revision
  localparam pchr_byte_t REV = 8'h3c;

  logic          i_clk = 1'b0;
  logic          i_reset = 1'b1;
  pchr_cfg_req_s i_cfg = '0;
  logic [7:0]    o_cfg_rdata;
  logic          o_cfg_rvalid;
  logic [15:0]   o_subsystem_vendor_code;
  int            num_errors = 0;
  int            compares = 0;
  int            exp_q[$];
  int            sv = 0;
  bit [1:0]      lk = '0;
  bit            p_rd = 1'b0;
  int            i;
  int            offs[12] = '{8'h06, 8'h07, 8'h08, 8'h0a, 8'h0b, 8'h0e, 8'h00, 8'h09, 8'h34, 8'hff, 8'h2c, 8'h2d};

  pchr_regs #(.REVISION_VALUE(REV)) dut
  (
    .i_clk                   (i_clk),
    .i_reset                 (i_reset),
    .i_cfg                   (i_cfg),
    .o_cfg_rdata             (o_cfg_rdata),
    .o_cfg_rvalid            (o_cfg_rvalid),
    .o_subsystem_vendor_code (o_subsystem_vendor_code)
  );

  always #20 i_clk = ~i_clk;

  // reference model of a byte read
  function automatic int mread(input int ad);
    case (ad)
      8'h06, 8'h0a, 8'h0e: return 8'h80;
      8'h08: return REV;
      8'h0b: return 8'h08;
      8'h2c: return sv & 8'hff;
      8'h2d: return (sv >> 8) & 8'hff;
      default: return 8'h00;
    endcase
  endfunction

  task automatic bad(input string m);
    num_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic stop_test();
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // checks the access taken at the last edge, then presents a new one
  task automatic step(input bit rd, input bit wr, input int ad, input int wd);
    int e;
    @(negedge i_clk);
    compares++;
    if (p_rd)
    begin
      e = exp_q.pop_front();
      if (o_cfg_rvalid !== 1'b1 || o_cfg_rdata !== e[7:0]) bad("read data");
    end
    else if (o_cfg_rvalid !== 1'b0) bad("stray valid");
    if (o_subsystem_vendor_code !== sv[15:0]) bad("vendor code");
    p_rd = rd;
    if (rd) exp_q.push_back(mread(ad));
    if (wr && (ad == 8'h2c || ad == 8'h2d) && !lk[ad-8'h2c])
    begin
      if (ad == 8'h2c) sv[7:0] = wd[7:0];
      else sv[15:8] = wd[7:0];
      lk[ad-8'h2c] = 1'b1;
    end
    i_cfg <= '{rd: rd, wr: wr, addr: ad[7:0], wdata: wd[7:0]};
  endtask

  task automatic do_reset();
    @(negedge i_clk);
    i_reset <= 1'b1;
    i_cfg <= '0;
    repeat (16) @(negedge i_clk);
    i_reset <= 1'b0;
    sv = 0;
    lk = '0;
    p_rd = 1'b0;
    exp_q.delete();
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    bad("timeout");
    stop_test();
  end

  initial
  begin
    void'($urandom(81246));
    do_reset();
    step(0, 0, 0, 0);
    if (o_cfg_rdata !== 8'h00) bad("reset data");
    // every offset read, written with random data and read again back to back
    foreach (offs[k])
    begin
      step(1, 0, offs[k], 0);
      step(1, 1, offs[k], $urandom_range(255));
      step(1, 0, offs[k], 0);
    end
    // all ones into the status bytes
    step(0, 1, 8'h06, 8'hff);
    step(0, 1, 8'h07, 8'hff);
    step(1, 0, 8'h06, 0);
    step(1, 0, 8'h07, 0);
    // locked vendor code ignores later writes
    step(0, 1, 8'h2c, 8'ha5);
    step(0, 1, 8'h2d, 8'h5a);
    step(1, 0, 8'h2c, 0);
    step(1, 0, 8'h2d, 0);
    // reset in mid-run clears both locks
    step(0, 0, 0, 0);
    do_reset();
    step(0, 0, 0, 0);
    step(0, 1, 8'h2d, 8'hc3);
    step(1, 0, 8'h2d, 0);
    step(0, 1, 8'h2c, 8'h3e);
    step(0, 1, 8'h2c, 8'h11);
    step(1, 0, 8'h2c, 0);
    for (i = 0; i < 300; i++)
      step($urandom_range(1), $urandom_range(1), offs[$urandom_range(11)], $urandom_range(255));
    step(0, 0, 0, 0);
    step(0, 0, 0, 0);
    stop_test();
  end
endmodule

`default_nettype wire
